// ### trpa_pkg.sv
// Purpose: Constants for the rate select and amplifier control block
// Assumes: APB, 32-bit data, one register per aligned word
// Notes:   Printed offsets are not all multiples of four; byte = 4*index
package trpa_pkg;

  // ==========================================================
  // Register indices and address width
  // ==========================================================
  localparam logic [11:0] IDX_SYMBOL_TICK_HIGH   = 12'h015;
  localparam logic [11:0] IDX_AMP_ON_LOW         = 12'h016;
  localparam logic [11:0] IDX_AMP_ON_HIGH        = 12'h017;
  localparam logic [11:0] IDX_TX_ON_FIFO         = 12'h018;
  localparam logic [11:0] IDX_SOFT_RESET         = 12'h02A;
  localparam logic [11:0] IDX_RF_STABILIZE       = 12'h02E;
  localparam logic [11:0] IDX_RATE_SELECT        = 12'h038;
  localparam logic [11:0] IDX_PREAMBLE_THRESH    = 12'h03B;
  localparam logic [11:0] IDX_CARRIER_THRESH     = 12'h03C;
  localparam logic [11:0] IDX_TEST_PIN_FUNCTION  = 12'h22F;
  localparam logic [11:0] IDX_RF_CONTROL         = 12'h300;
  localparam logic [11:0] IDX_RF_STATUS          = 12'h301;
  localparam int          ADDR_W                 = 14;

  // ==========================================================
  // Field positions and values
  // ==========================================================
  localparam int          HIGH_RATE_BIT          = 0;
  localparam int          BB_RESET_BIT           = 1;
  localparam int          PREVALID_LSB           = 4;
  localparam int          CS_LEVEL_LSB           = 5;
  localparam int          TEST_FN_LSB            = 0;
  localparam logic [3:0]  PREVALID_HIGH_RATE     = 4'h3;
  localparam logic [2:0]  CS_LEVEL_HIGH_RATE     = 3'h2;
  localparam logic [2:0]  TEST_FN_AMP_CTRL       = 3'h7;
  localparam logic [7:0]  REG_RESET_VALUE        = 8'h00;

  // Rates in kbps, and baseband clock divisors from 100 MHz
  localparam int          RATE_NORMAL_KBPS       = 250;
  localparam int          RATE_HIGH_KBPS         = 625;
  localparam int          CLK_KHZ                = 100000;
  localparam int          DIV_NORMAL = CLK_KHZ / RATE_NORMAL_KBPS;
  localparam int          DIV_HIGH   = CLK_KHZ / RATE_HIGH_KBPS;
  localparam int          DIV_W      = 10;

  typedef enum logic [1:0] {
    TRPA_RF_IDLE,
    TRPA_RF_RX,
    TRPA_RF_TX
  } trpa_rf_state_t;

endpackage : trpa_pkg

// ### trpa_bb_if.sv
// Purpose: Link between register file and baseband timing engine
// Assumes: Single clock domain
// Notes:   Carries settings down and state up
`timescale 1ns/1ps
interface trpa_bb_if;
  logic       high_rate;
  logic       bb_reset;
  logic [3:0] preamble_valid_threshold;
  logic [2:0] carrier_sense_level;
  logic       bit_tick;
  logic       rate_active;

  modport ctrl (output high_rate, output bb_reset,
                output preamble_valid_threshold,
                output carrier_sense_level,
                input  bit_tick, input rate_active);
  modport eng  (input  high_rate, input bb_reset,
                input  preamble_valid_threshold,
                input  carrier_sense_level,
                output bit_tick, output rate_active);
endinterface : trpa_bb_if

// ### trpa_bb_engine.sv
// Purpose: Baseband bit timing at normal or high rate
// Assumes: 100 MHz clock
// Notes:   Only the rate latches, at a baseband reset; thresholds are unused
`timescale 1ns/1ps
module trpa_bb_engine
  import trpa_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  trpa_bb_if.eng    bb
);

  logic [DIV_W-1:0] cnt_reg;
  logic             rate_reg;
  logic             tick_reg;
  logic [DIV_W-1:0] limit;
  logic             wrap;

  assign limit = rate_reg ? DIV_W'(DIV_HIGH - 1) : DIV_W'(DIV_NORMAL - 1);
  assign wrap  = (cnt_reg == limit);
  assign bb.bit_tick    = tick_reg;
  assign bb.rate_active = rate_reg;

  // ==========================================================
  // Rate latch and bit divider
  // ==========================================================
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rate_reg <= 1'b0;
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else if (bb.bb_reset) begin
      rate_reg <= bb.high_rate;
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= wrap ? '0 : cnt_reg + 1'b1;
      tick_reg <= wrap;
    end
  end

  a_tick_spacing : assert property (@(posedge core_clk_i)
    disable iff (reset_i)
    $rose(tick_reg) && rate_reg |=> (!tick_reg) [*8])
    else $error("bit tick spacing too short at high rate");

endmodule : trpa_bb_engine

// ### trpa_rate_pa_ctrl.sv
// Purpose: Rate select and amplifier pin control with APB registers
// Assumes: APB slave, pins synchronous to core clock
// Notes:   Byte address is four times the register index
`timescale 1ns/1ps

// Summary of operation
// - High-rate mode runs the baseband at 625 kbps instead of 250 kbps.
// - Bit 0 of baseband_rate_select enables high rate.
// - Writing one to baseband_reset applies the new baseband rate setting.
// - Test function 111 hands three pins to the RF state machine.
// - Pins 0,1 low in receive, high in transmit; pin 2 inverse.
module trpa_rate_pa_ctrl
  import trpa_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              reset_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  input  wire logic [3:0]        pstrb_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic              rf_rx_i,
  input  wire logic              rf_tx_i,
  input  wire logic [2:0]        gpio_in_i,
  output logic      [2:0]        gpio_out_o,
  output logic      [2:0]        gpio_oe_n_o,
  output logic                   high_rate_o,
  output logic                   bit_tick_o
);

  // ==========================================================
  // Register storage
  // ==========================================================
  logic [7:0] sym_tick_reg, amp_lo_reg, amp_hi_reg, tx_on_reg;
  logic [7:0] soft_rst_reg, stab_reg, rate_reg, pre_reg, cs_reg;
  logic [7:0] test_reg, gpio_val_reg, gpio_dir_reg;
  logic [31:0] prdata_reg, prdata_next;
  logic        pready_reg, pslverr_reg;
  logic        bb_reset_reg;
  logic [2:0]  gpio_out_reg, gpio_out_next;
  logic [2:0]  gpio_oe_n_reg, gpio_oe_n_next;
  logic        high_rate_reg, tick_reg;
  trpa_rf_state_t rf_state_reg, rf_state_next;

  trpa_bb_if bb ();

  function automatic logic [11:0] idx_of(input logic [ADDR_W-1:0] a);
    idx_of = a[ADDR_W-1:2];
  endfunction : idx_of

  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic [7:0] wd,
                                       input logic       en);
    merge = en ? wd : old;
  endfunction : merge

  // ==========================================================
  // APB decode
  // ==========================================================
  wire        setup_ph  = psel_i && !penable_i;
  wire        access_ph = psel_i && penable_i && pready_reg;
  wire [11:0] idx       = idx_of(paddr_i);
  wire        wr_en     = access_ph && pwrite_i && pstrb_i[0];
  wire        aligned   = (paddr_i[1:0] == 2'b00);
  wire        hit_known =
      (idx == IDX_SYMBOL_TICK_HIGH) || (idx == IDX_AMP_ON_LOW)   ||
      (idx == IDX_AMP_ON_HIGH)      || (idx == IDX_TX_ON_FIFO)   ||
      (idx == IDX_SOFT_RESET)       || (idx == IDX_RF_STABILIZE) ||
      (idx == IDX_RATE_SELECT)      || (idx == IDX_PREAMBLE_THRESH) ||
      (idx == IDX_CARRIER_THRESH)   || (idx == IDX_TEST_PIN_FUNCTION) ||
      (idx == IDX_RF_CONTROL)       || (idx == IDX_RF_STATUS);
  wire        hit       = hit_known && aligned;
  wire        wr_hit    = wr_en && hit;

  wire w_sym  = wr_hit && (idx == IDX_SYMBOL_TICK_HIGH);
  wire w_alo  = wr_hit && (idx == IDX_AMP_ON_LOW);
  wire w_ahi  = wr_hit && (idx == IDX_AMP_ON_HIGH);
  wire w_txo  = wr_hit && (idx == IDX_TX_ON_FIFO);
  wire w_srst = wr_hit && (idx == IDX_SOFT_RESET);
  wire w_stab = wr_hit && (idx == IDX_RF_STABILIZE);
  wire w_rate = wr_hit && (idx == IDX_RATE_SELECT);
  wire w_pre  = wr_hit && (idx == IDX_PREAMBLE_THRESH);
  wire w_cs   = wr_hit && (idx == IDX_CARRIER_THRESH);
  wire w_test = wr_hit && (idx == IDX_TEST_PIN_FUNCTION);
  wire w_gpio = wr_hit && (idx == IDX_RF_CONTROL);

  // ==========================================================
  // Register writes
  // ==========================================================
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      sym_tick_reg <= REG_RESET_VALUE;
      amp_lo_reg   <= REG_RESET_VALUE;
      amp_hi_reg   <= REG_RESET_VALUE;
      tx_on_reg    <= REG_RESET_VALUE;
      soft_rst_reg <= REG_RESET_VALUE;
      stab_reg     <= REG_RESET_VALUE;
      rate_reg     <= REG_RESET_VALUE;
      pre_reg      <= REG_RESET_VALUE;
      cs_reg       <= REG_RESET_VALUE;
      test_reg     <= REG_RESET_VALUE;
      gpio_val_reg <= REG_RESET_VALUE;
    end else begin
      sym_tick_reg <= merge(sym_tick_reg, pwdata_i[7:0], w_sym);
      amp_lo_reg   <= merge(amp_lo_reg, pwdata_i[7:0], w_alo);
      amp_hi_reg   <= merge(amp_hi_reg, pwdata_i[7:0], w_ahi);
      tx_on_reg    <= merge(tx_on_reg, pwdata_i[7:0], w_txo);
      soft_rst_reg <= merge(soft_rst_reg, pwdata_i[7:0], w_srst);
      stab_reg     <= merge(stab_reg, pwdata_i[7:0], w_stab);
      rate_reg     <= merge(rate_reg, pwdata_i[7:0], w_rate);
      pre_reg      <= merge(pre_reg, pwdata_i[7:0], w_pre);
      cs_reg       <= merge(cs_reg, pwdata_i[7:0], w_cs);
      test_reg     <= merge(test_reg, pwdata_i[7:0], w_test);
      gpio_val_reg <= merge(gpio_val_reg, pwdata_i[7:0], w_gpio);
    end
  end

  // Direction register lives in upper byte of the pin control word
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      gpio_dir_reg <= REG_RESET_VALUE;
    end else if (w_gpio && pstrb_i[1]) begin
      gpio_dir_reg <= pwdata_i[15:8];
    end
  end

  // One-cycle baseband reset pulse from the self-clearing bit
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      bb_reset_reg <= 1'b0;
    end else begin
      bb_reset_reg <= w_srst && pwdata_i[BB_RESET_BIT];
    end
  end

  // ==========================================================
  // Baseband engine
  // ==========================================================
  assign bb.high_rate = rate_reg[HIGH_RATE_BIT];
  assign bb.bb_reset  = bb_reset_reg;
  assign bb.preamble_valid_threshold = pre_reg[PREVALID_LSB +: 4];
  assign bb.carrier_sense_level      = cs_reg[CS_LEVEL_LSB +: 3];

  trpa_bb_engine trpa_bb_engine_inst (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .bb         (bb.eng)
  );

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      high_rate_reg <= 1'b0;
      tick_reg      <= 1'b0;
    end else begin
      high_rate_reg <= bb.rate_active;
      tick_reg      <= bb.bit_tick;
    end
  end

  // ==========================================================
  // RF state tracking
  // ==========================================================
  always_comb begin
    unique case ({rf_tx_i, rf_rx_i})
      2'b10, 2'b11: rf_state_next = TRPA_RF_TX;
      2'b01:        rf_state_next = TRPA_RF_RX;
      default:      rf_state_next = TRPA_RF_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rf_state_reg <= TRPA_RF_IDLE;
    end else begin
      rf_state_reg <= rf_state_next;
    end
  end

  // ==========================================================
  // Pin function
  // ==========================================================
  wire amp_mode = (test_reg[TEST_FN_LSB +: 3] == TEST_FN_AMP_CTRL);
  wire in_tx    = (rf_state_reg == TRPA_RF_TX);
  wire in_rx    = (rf_state_reg == TRPA_RF_RX);
  wire rf_move  = in_tx || in_rx;

  always_comb begin
    gpio_out_next  = gpio_val_reg[2:0];
    gpio_oe_n_next = ~gpio_dir_reg[2:0];
    if (amp_mode) begin
      gpio_oe_n_next = 3'b000;
      if (rf_move) begin
        gpio_out_next = in_tx ? 3'b011 : 3'b100;
      end else begin
        gpio_out_next = gpio_out_reg;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      gpio_out_reg  <= 3'b000;
      gpio_oe_n_reg <= 3'b111;
    end else begin
      gpio_out_reg  <= gpio_out_next;
      gpio_oe_n_reg <= gpio_oe_n_next;
    end
  end

  // ==========================================================
  // APB answer
  // ==========================================================
  always_comb begin
    prdata_next = 32'h0000_0000;
    unique case (idx)
      IDX_SYMBOL_TICK_HIGH:  prdata_next[7:0] = sym_tick_reg;
      IDX_AMP_ON_LOW:        prdata_next[7:0] = amp_lo_reg;
      IDX_AMP_ON_HIGH:       prdata_next[7:0] = amp_hi_reg;
      IDX_TX_ON_FIFO:        prdata_next[7:0] = tx_on_reg;
      IDX_SOFT_RESET:        prdata_next[7:0] = soft_rst_reg & 8'hFD;
      IDX_RF_STABILIZE:      prdata_next[7:0] = stab_reg;
      IDX_RATE_SELECT:       prdata_next[7:0] = rate_reg;
      IDX_PREAMBLE_THRESH:   prdata_next[7:0] = pre_reg;
      IDX_CARRIER_THRESH:    prdata_next[7:0] = cs_reg;
      IDX_TEST_PIN_FUNCTION: prdata_next[7:0] = test_reg;
      IDX_RF_CONTROL:
        prdata_next[15:0] = {gpio_dir_reg, gpio_val_reg};
      IDX_RF_STATUS:
        prdata_next[7:0] = {2'b00, high_rate_reg, in_tx, in_rx,
                            gpio_in_i};
      default:               prdata_next = 32'h0000_0000;
    endcase
  end

  // No wait states: ready rises in the first access cycle
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= setup_ph;
      pslverr_reg <= setup_ph && !hit;
      if (setup_ph && !pwrite_i) begin
        prdata_reg <= hit ? prdata_next : 32'h0000_0000;
      end
    end
  end

  assign prdata_o    = prdata_reg;
  assign pready_o    = pready_reg;
  assign pslverr_o   = pslverr_reg;
  assign gpio_out_o  = gpio_out_reg;
  assign gpio_oe_n_o = gpio_oe_n_reg;
  assign high_rate_o = high_rate_reg;
  assign bit_tick_o  = tick_reg;

  // ==========================================================
  // Checks
  // ==========================================================
  sequence s_tx_seen;
    amp_mode && in_tx;
  endsequence

  sequence s_rx_seen;
    amp_mode && in_rx;
  endsequence

  a_tx_pin_levels : assert property (@(posedge core_clk_i)
    disable iff (reset_i)
    s_tx_seen |=> (gpio_out_o == 3'b011) || !$past(amp_mode))
    else $error("pins wrong while transmitting");

  a_rx_pin_levels : assert property (@(posedge core_clk_i)
    disable iff (reset_i)
    s_rx_seen |=> (gpio_out_o == 3'b100) || !$past(amp_mode))
    else $error("pins wrong while receiving");

  a_pins_hold_idle : assert property (@(posedge core_clk_i)
    disable iff (reset_i)
    amp_mode && !rf_move && $past(amp_mode) |=> $stable(gpio_out_o))
    else $error("pins moved outside a state change");

  a_amp_drive_on : assert property (@(posedge core_clk_i)
    disable iff (reset_i)
    amp_mode |=> gpio_oe_n_o == 3'b000)
    else $error("pins not driven in amplifier mode");

  a_rate_bit_store : assert property (@(posedge core_clk_i)
    disable iff (reset_i)
    w_rate |=> bb.high_rate == $past(pwdata_i[HIGH_RATE_BIT]))
    else $error("rate bit not stored");

  a_bb_reset_apply : assert property (@(posedge core_clk_i)
    disable iff (reset_i)
    w_srst && pwdata_i[BB_RESET_BIT] |->
      ##3 high_rate_o == $past(bb.high_rate, 2))
    else $error("baseband reset did not apply rate");

  a_rate_hold : assert property (@(posedge core_clk_i)
    disable iff (reset_i)
    !bb_reset_reg |=> bb.rate_active == $past(bb.rate_active))
    else $error("rate changed without baseband reset");

  a_apb_ready : assert property (@(posedge core_clk_i)
    disable iff (reset_i)
    setup_ph |=> pready_o ##1 !pready_o)
    else $error("ready not one cycle after setup");

endmodule : trpa_rate_pa_ctrl

// ### trpa_amp_model.sv
// Purpose: External amplifier, low-noise amplifier and switch model
// Assumes: Pins sampled on the core clock
// Notes:   An undriven pin shows the inverse of its last driven level
`timescale 1ns/1ps
module trpa_amp_model (
  input  wire logic       core_clk_i,
  input  wire logic [2:0] gpio_out_i,
  input  wire logic [2:0] gpio_oe_n_i,
  output logic      [2:0] pin_level_o,
  output logic            pa_on_o,
  output logic            lna_on_o
);
  logic [2:0] last_reg = 3'h0;
  logic [2:0] float_lvl;

  // ==========================================================
  // Pin resolution
  // ==========================================================
  assign float_lvl   = ~last_reg;
  assign pin_level_o = (gpio_out_i & ~gpio_oe_n_i) |
                       (float_lvl & gpio_oe_n_i);
  // Remember only levels that were actually driven
  always @(posedge core_clk_i) begin
    last_reg <= (gpio_out_i & ~gpio_oe_n_i) | (last_reg & gpio_oe_n_i);
  end

  // ==========================================================
  // Amplifier and switch decode
  // ==========================================================
  assign pa_on_o  = (pin_level_o === 3'h3);
  assign lna_on_o = (pin_level_o === 3'h4);
endmodule : trpa_amp_model

// ### trpa_rate_pa_ctrl_tb.sv
// Purpose: Self-checking bench for rate select and amplifier pins
// Assumes: APB master in this bench, amplifier model on the pins
// Notes:   Byte address is four times the register index
`timescale 1ns/1ps
module trpa_rate_pa_ctrl_tb
  import trpa_pkg::*;
;
  logic              core_clk_i = 1'b0;
  logic              reset_i    = 1'b1;
  logic              psel_i     = 1'b0;
  logic              penable_i  = 1'b0;
  logic              pwrite_i   = 1'b0;
  logic [ADDR_W-1:0] paddr_i    = '0;
  logic [31:0]       pwdata_i   = '0;
  logic [3:0]        pstrb_i    = 4'hF;
  logic              rf_rx_i    = 1'b0;
  logic              rf_tx_i    = 1'b0;
  logic [31:0]       prdata_o;
  logic              pready_o, pslverr_o, high_rate_o, bit_tick_o;
  logic [2:0]        gpio_in_i, gpio_out_o, gpio_oe_n_o;
  logic              pa_on, lna_on;
  int                miscompares = 0;
  int                checks_done = 0;

  always #5 core_clk_i = ~core_clk_i;

  trpa_rate_pa_ctrl trpa_rate_pa_ctrl_inst (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .rf_rx_i(rf_rx_i),
    .rf_tx_i(rf_tx_i), .gpio_in_i(gpio_in_i), .gpio_out_o(gpio_out_o),
    .gpio_oe_n_o(gpio_oe_n_o), .high_rate_o(high_rate_o),
    .bit_tick_o(bit_tick_o));

  trpa_amp_model trpa_amp_model_inst (
    .core_clk_i(core_clk_i), .gpio_out_i(gpio_out_o),
    .gpio_oe_n_i(gpio_oe_n_o), .pin_level_o(gpio_in_i),
    .pa_on_o(pa_on), .lna_on_o(lna_on));

  // ==========================================================
  // Shared tasks
  // ==========================================================
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [31:0] wd, input logic [3:0] st,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge core_clk_i);
    psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= wr;
    paddr_i <= a; pwdata_i <= wd; pstrb_i <= st;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
      if (n > 20) begin
        miscompares++;
        end_of_test();
      end
    end while (pready_o !== 1'b1);
    rd = prdata_o; err = pslverr_o;
    psel_i <= 1'b0; penable_i <= 1'b0;
  endtask : apb

  task automatic wr_reg(input logic [11:0] idx, input logic [31:0] d);
    logic [31:0] rd;
    logic        e;
    apb(1'b1, {idx, 2'b00}, d, 4'hF, rd, e);
    chk({31'h0, e}, 32'h0);
  endtask : wr_reg

  task automatic rd_chk(input logic [11:0] idx, input logic [31:0] x);
    logic [31:0] rd;
    logic        e;
    apb(1'b0, {idx, 2'b00}, 32'h0, 4'hF, rd, e);
    chk(rd, x);
  endtask : rd_chk

  task automatic tick_period(input int exp);
    int n;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
      if (n > 1000) begin
        miscompares++;
        end_of_test();
      end
    end while (bit_tick_o !== 1'b1);
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (bit_tick_o !== 1'b1 && n < 1000);
    chk(n, exp);
  endtask : tick_period

  task automatic wait_rate(input logic v);
    int n;
    n = 0;
    while (high_rate_o !== v && n < 10) begin
      @(posedge core_clk_i);
      n++;
    end
    chk({31'h0, high_rate_o}, {31'h0, v});
  endtask : wait_rate

  task automatic step_chk(input int n, input logic [2:0] exp);
    repeat (n) @(posedge core_clk_i);
    #1;
    chk({29'h0, gpio_out_o}, {29'h0, exp});
  endtask : step_chk

  // ==========================================================
  // Scenarios
  // ==========================================================
  logic [11:0] idx_tab [10] = '{IDX_SYMBOL_TICK_HIGH, IDX_AMP_ON_LOW,
    IDX_AMP_ON_HIGH, IDX_TX_ON_FIFO, IDX_SOFT_RESET, IDX_RF_STABILIZE,
    IDX_RATE_SELECT, IDX_PREAMBLE_THRESH, IDX_CARRIER_THRESH,
    IDX_TEST_PIN_FUNCTION};

  task automatic t_reset;
    chk({29'h0, gpio_oe_n_o}, 32'h7);
    chk({29'h0, gpio_out_o}, 32'h0);
    chk({31'h0, high_rate_o}, 32'h0);
    foreach (idx_tab[i]) rd_chk(idx_tab[i], {24'h0, REG_RESET_VALUE});
    tick_period(DIV_NORMAL);
    $display("test reset done");
  endtask : t_reset

  task automatic t_regs;
    logic [31:0] rd;
    logic        e;
    foreach (idx_tab[i]) wr_reg(idx_tab[i], 32'hFFFF_FF5A);
    foreach (idx_tab[i])
      rd_chk(idx_tab[i], (idx_tab[i] == IDX_SOFT_RESET) ? 32'h58 : 32'h5A);
    apb(1'b0, 14'h0400, 32'h0, 4'hF, rd, e);
    chk({e, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, {IDX_RATE_SELECT, 2'b01}, 32'h1, 4'hF, rd, e);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, {IDX_RATE_SELECT, 2'b00}, 32'h1, 4'h0, rd, e);
    rd_chk(IDX_RATE_SELECT, 32'h5A);
    $display("test registers done");
  endtask : t_regs

  task automatic t_rate;
    wr_reg(IDX_RATE_SELECT, 32'h01);
    wr_reg(IDX_PREAMBLE_THRESH, {24'h0, PREVALID_HIGH_RATE, 4'h0});
    wr_reg(IDX_CARRIER_THRESH, {24'h0, CS_LEVEL_HIGH_RATE, 5'h0});
    repeat (12) @(posedge core_clk_i);
    chk({31'h0, high_rate_o}, 32'h0);
    wr_reg(IDX_SOFT_RESET, 32'h02);
    wait_rate(1'b1);
    tick_period(DIV_HIGH);
    wr_reg(IDX_RATE_SELECT, 32'h00);
    wr_reg(IDX_SOFT_RESET, 32'h02);
    wait_rate(1'b0);
    tick_period(DIV_NORMAL);
    $display("test rate done");
  endtask : t_rate

  task automatic t_pins;
    wr_reg(IDX_RF_CONTROL, 32'h0000_0705);
    rd_chk(IDX_RF_STATUS, 32'h05);
    chk({29'h0, gpio_out_o}, 32'h5);
    chk({29'h0, gpio_oe_n_o}, 32'h0);
    rd_chk(IDX_RF_CONTROL, 32'h0705);
    wr_reg(IDX_RF_CONTROL, 32'h0);
    rd_chk(IDX_RF_STATUS, 32'h02);
    chk({29'h0, gpio_oe_n_o}, 32'h7);
    $display("test manual pins done");
  endtask : t_pins

  task automatic t_no_amp;
    wr_reg(IDX_TEST_PIN_FUNCTION, 32'h06);
    @(posedge core_clk_i);
    rf_tx_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    #1;
    chk({29'h0, gpio_oe_n_o}, 32'h7);
    @(posedge core_clk_i);
    rf_tx_i <= 1'b0;
    $display("test no amplifier mode done");
  endtask : t_no_amp

  task automatic t_amp;
    wr_reg(IDX_TEST_PIN_FUNCTION, {29'h0, TEST_FN_AMP_CTRL});
    @(posedge core_clk_i);
    rf_rx_i <= 1'b1;
    step_chk(2, 3'h4);
    chk({29'h0, gpio_oe_n_o}, 32'h0);
    chk({31'h0, lna_on}, 32'h1);
    repeat (5) step_chk(1, 3'h4);
    @(posedge core_clk_i);
    rf_tx_i <= 1'b1;
    step_chk(1, 3'h4);
    step_chk(1, 3'h3);
    chk({31'h0, pa_on}, 32'h1);
    @(posedge core_clk_i);
    rf_tx_i <= 1'b0;
    rf_rx_i <= 1'b0;
    step_chk(4, 3'h3);
    @(posedge core_clk_i);
    rf_rx_i <= 1'b1;
    step_chk(2, 3'h4);
    $display("test amplifier mode done");
  endtask : t_amp

  // ==========================================================
  // Main sequence and watchdog
  // ==========================================================
  initial begin
    repeat (16) @(posedge core_clk_i);
    reset_i <= 1'b0;
    @(posedge core_clk_i);
    #1;
    t_reset();
    t_regs();
    t_rate();
    t_pins();
    t_no_amp();
    t_amp();
    end_of_test();
  end

  initial begin
    #500000;
    miscompares++;
    end_of_test();
  end
endmodule : trpa_rate_pa_ctrl_tb
